// ===== bench/i2c_seq_monitor.sv
// Checker for the sequencer status flags and open-drain line controls.
// Assumes it is bound to the sequencer top and sees only its ports.
`timescale 1ns/1ps
module i2c_seq_monitor (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Requests.
	input wire logic start_req_i,
	input wire logic rstart_req_i,
	input wire logic buf_wr_i,
	input wire logic write_collision_flag_clr_i,
	// Configuration, needed to judge the clock high time.
	input wire logic [i2c_seq_pkg::RELOAD_W-1:0] baud_reload_i,
	// Status and lines.
	input wire logic start_enable_o,
	input wire logic repeated_start_o,
	input wire logic buffer_full_o,
	input wire logic write_collision_o,
	input wire logic start_seen_o,
	input wire logic collision_o,
	input wire logic port_interrupt_o,
	input wire logic [i2c_seq_pkg::DATA_W-1:0] transfer_buffer_o,
	input wire logic clock_line_o,
	input wire logic clock_line_oe_n_o,
	input wire logic data_line_o,
	input wire logic data_line_oe_n_o
);
	default clocking cb @(posedge clk_i); endclocking
	default disable iff (!rst_n_i);

	// Clock pulled low soon after a write fills the buffer.
	sequence s_pull;
		##[0:2] !clock_line_oe_n_o;
	endsequence
	// A released clock stays released while it is resampled.
	sequence s_high;
		clock_line_oe_n_o [*2];
	endsequence

	// Cycles the clock has stood released, saturating. A high phase shorter
	// than two clock cycles per reload unit would starve a slow slave.
	logic [7:0] high_cnt_r;
	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			high_cnt_r <= 8'h00;
		end else if (!clock_line_oe_n_o) begin
			high_cnt_r <= 8'h00;
		end else if (high_cnt_r != 8'hff) begin
			high_cnt_r <= high_cnt_r + 8'h01;
		end
	end

	a_lines_open_drain: assert property (!clock_line_o && !data_line_o)
		else $error("bus line driven high");
	a_full_from_write: assert property (
		$rose(buffer_full_o) |-> $past(buf_wr_i))
		else $error("buffer full without write");
	a_full_pulls_clock: assert property (
		$rose(buffer_full_o) |-> s_pull)
		else $error("clock not pulled after write");
	a_high_phase_min: assert property (
		$rose(clock_line_oe_n_o) |-> s_high)
		else $error("clock high phase too short");
	a_high_phase_reload: assert property (
		$fell(clock_line_oe_n_o) |->
		high_cnt_r >= {baud_reload_i, 1'b0})
		else $error("clock high phase shorter than reload");
	a_start_drops_write: assert property (
		start_enable_o && buf_wr_i |=>
		write_collision_o && $stable(transfer_buffer_o))
		else $error("write during start not refused");
	a_rstart_drops_write: assert property (
		repeated_start_o && buf_wr_i |=>
		write_collision_o && $stable(transfer_buffer_o))
		else $error("write during repeated start not refused");
	a_write_collision_flag_stays_set: assert property (
		write_collision_o && !write_collision_flag_clr_i |=> write_collision_o)
		else $error("write collision cleared by itself");
	a_busy_no_request: assert property (
		buffer_full_o && (start_req_i || rstart_req_i) |=>
		!start_enable_o && !repeated_start_o)
		else $error("request taken while busy");
	a_seen_with_drive: assert property (
		$rose(start_seen_o) |-> !data_line_oe_n_o)
		else $error("start seen without data pulled");
	a_start_end_irq: assert property (
		$fell(start_enable_o) && !collision_o |->
		##[0:1] port_interrupt_o)
		else $error("start ended without interrupt");
endmodule : i2c_seq_monitor

bind i2c_master_bit_sequencer i2c_seq_monitor mon (
	.clk_i, .rst_n_i, .start_req_i, .rstart_req_i, .buf_wr_i,
	.write_collision_flag_clr_i, .baud_reload_i, .start_enable_o, .repeated_start_o,
	.buffer_full_o, .write_collision_o, .start_seen_o, .collision_o,
	.port_interrupt_o, .transfer_buffer_o, .clock_line_o,
	.clock_line_oe_n_o, .data_line_o, .data_line_oe_n_o);

// ===== bench/i2c_slave_model.sv
// Behavioural slave on the two-wire bus with pull-ups, ack and stretching.
// Assumes the master's enables are low while it pulls a line down.
`timescale 1ns/1ps
module i2c_slave_model (
	// Clock.
	input wire logic clk_i,
	// Master enables and behaviour controls.
	input wire logic scl_oe_n_i,
	input wire logic sda_oe_n_i,
	input wire logic ack_en_i,
	input wire logic stretch_i,
	input wire logic jam_i,
	// Resolved lines and received byte.
	output logic scl_o,
	output logic sda_o,
	output logic [7:0] rx_byte_o
);
	logic scl_q = 1'b1;
	logic sda_q = 1'b1;
	logic ack_drv = 1'b0;
	logic [3:0] hold = 4'h0;
	logic [3:0] cnt = 4'h0;
	logic [7:0] rx = 8'h00;

	// Wired-and over pull-ups, so a released line reads high.
	assign scl_o = scl_oe_n_i && (hold == 4'h0);
	assign sda_o = sda_oe_n_i && !ack_drv && !jam_i;
	assign rx_byte_o = rx;

	// Bits counted on clock rise; ack and stretch begin on clock fall.
	always_ff @(posedge clk_i) begin
		scl_q <= scl_o;
		sda_q <= sda_o;
		if (hold != 4'h0)
			hold <= hold - 4'h1;
		else if (scl_q && !scl_o && stretch_i)
			hold <= 4'ha;
		if (scl_o && sda_q && !sda_o)
			cnt <= 4'h0;
		else if (!scl_q && scl_o) begin
			if (cnt < 4'h8)
				rx <= {rx[6:0], sda_o};
			cnt <= cnt + 4'h1;
		end else if (scl_q && !scl_o && cnt == 4'h9)
			cnt <= 4'h0;
		if (scl_q && !scl_o)
			ack_drv <= (cnt == 4'h8) && ack_en_i;
	end
endmodule : i2c_slave_model

// ===== bench/testbench.sv
// Self-checking bench: start, bytes with ack and nack, repeated start,
// refused requests and a start collision.
// Assumes the sequencer and the slave model files are compiled first.
`timescale 1ns/1ps
module testbench;
	logic clk_i = 1'b0;
	logic rst_n_i = 1'b0;
	logic [5:0] rq = 6'h00;
	logic [7:0] wd = 8'h00;
	logic ack_en = 1'b1;
	logic stretch = 1'b0;
	logic jam = 1'b0;
	logic [6:0] reload = 7'h02;
	logic scl_oe_n, sda_oe_n, scl, sda;
	logic st_en, rs, bf, write_collision_flag, ackst, seen, coll, irq;
	logic [7:0] buf_q, rx;
	int err_total = 0;
	int checked = 0;

	// System clock, 8 ns period.
	always #4 clk_i = ~clk_i;

	i2c_master_bit_sequencer dut (.clk_i(clk_i), .rst_n_i(rst_n_i),
		.baud_reload_i(reload), .start_req_i(rq[0]), .rstart_req_i(rq[1]),
		.buf_wr_i(rq[2]), .buf_data_i(wd), .write_collision_flag_clr_i(rq[3]),
		.coll_clr_i(rq[4]), .irq_clr_i(rq[5]), .start_enable_o(st_en),
		.repeated_start_o(rs), .buffer_full_o(bf), .write_collision_o(write_collision_flag),
		.ack_status_o(ackst), .start_seen_o(seen), .collision_o(coll),
		.port_interrupt_o(irq), .transfer_buffer_o(buf_q),
		.clock_line_i(scl), .clock_line_o(), .clock_line_oe_n_o(scl_oe_n),
		.data_line_i(sda), .data_line_o(), .data_line_oe_n_o(sda_oe_n));

	i2c_slave_model peer (.clk_i(clk_i), .scl_oe_n_i(scl_oe_n),
		.sda_oe_n_i(sda_oe_n), .ack_en_i(ack_en), .stretch_i(stretch),
		.jam_i(jam), .scl_o(scl), .sda_o(sda), .rx_byte_o(rx));

	task automatic test_done();
		if (err_total == 0 && checked > 0)
			$display("== PASSED ==");
		else
			$display("== FAILED ==");
		$finish;
	endtask : test_done

	// Wide enough for a flag joined to the whole buffer.
	task automatic chk(input string nm, input logic [15:0] s,
		input logic [15:0] e);
		checked++;
		if (s !== e) begin
			err_total++;
			$display("mismatch %s expected %h seen %h", nm, e, s);
		end
	endtask : chk

	// One-cycle request pulse; flags are settled on return.
	task automatic req(input logic [5:0] m, input logic [7:0] d);
		@(posedge clk_i);
		rq <= m;
		wd <= d;
		@(posedge clk_i);
		rq <= 6'h00;
		#1;
	endtask : req

	// Bounded wait for the event flag; running out ends the run.
	task automatic wait_irq();
		int n;
		n = 0;
		while (irq !== 1'b1 && n < 4000) begin
			@(posedge clk_i);
			#1;
			n++;
		end
		if (n >= 4000) begin
			err_total++;
			test_done();
		end
	endtask : wait_irq

	// Sends a byte; an ack byte gets an early rewrite, a nack byte a late one.
	task automatic send(input logic [7:0] d, input logic nack);
		if (!nack)
			req(6'h04, ~d);
		req(6'h04, d);
		chk("full", bf, 8'h01);
		chk("write_collision_flag_early", write_collision_flag, {7'h0, !nack});
		if (nack) begin
			repeat (20) @(posedge clk_i);
			req(6'h07, 8'hff);
			chk("write_collision_flag_late", {write_collision_flag, st_en, rs}, 8'h04);
		end
		wait_irq();
		chk("rx_byte", rx, d);
		chk("buffer", buf_q, d);
		chk("ack", {ackst, bf, scl_oe_n}, {5'h0, nack, 2'b00});
		req(6'h28, 8'h00);
	endtask : send

	// Main sequence.
	initial begin
		repeat (10) @(posedge clk_i);
		rst_n_i <= 1'b1;
		repeat (3) @(posedge clk_i);
		#1;
		chk("reset", {bf, write_collision_flag, seen, coll, irq, st_en, scl_oe_n, sda_oe_n}, 8'h03);
		chk("reset_buf", buf_q, 8'h00);
		req(6'h01, 8'h00);
		chk("start_en", st_en, 8'h01);
		req(6'h04, 8'h5a);
		chk("start_wr", {write_collision_flag, buf_q}, 16'h0100);
		wait_irq();
		chk("start_done", {st_en, seen, sda_oe_n, scl_oe_n, coll}, 8'h0a);
		req(6'h28, 8'h00);
		chk("write_collision_flag_clr", {write_collision_flag, irq}, 8'h00);
		send(8'ha6, 1'b0);
		@(posedge clk_i);
		ack_en <= 1'b0;
		stretch <= 1'b1;
		reload <= 7'h03;
		send(8'h3c, 1'b1);
		req(6'h02, 8'h00);
		chk("rstart_set", rs, 8'h01);
		req(6'h04, 8'h11);
		chk("rstart_wr", {write_collision_flag, buf_q}, 16'h013c);
		wait_irq();
		chk("rstart_done", {rs, seen, sda_oe_n, coll}, 8'h04);
		@(posedge clk_i);
		jam <= 1'b1;
		req(6'h29, 8'h00);
		repeat (4) @(posedge clk_i);
		#1;
		chk("collide", {coll, st_en, seen}, 8'h05);
		req(6'h10, 8'h00);
		chk("coll_clr", coll, 8'h00);
		test_done();
	end

	// Watchdog well beyond the expected run length.
	initial begin
		#200000;
		err_total++;
		test_done();
	end
endmodule : testbench

// ===== src/i2c_master_bit_sequencer.sv
// Master-side bit sequencer of one serial port: baud counter, start and
// repeated start generation, byte transmit with acknowledge sampling.
// Assumes the bus lines are open drain with external pull-ups, and that the
// control pulses come from software logic on clk_i.
`timescale 1ns/1ps

// Notes on behaviour
// - Each instance owns its reload input and counter, so rates are free.
// - Counter steps twice per instruction cycle, stops at zero until reload.
// - Counter holds while released clock line is not yet seen high.
// - Clock seen high reloads counter, so high time lasts one period.
// - Start request with both lines high reloads counter, begins start.
// - Lines still high at expiry: pull data low, set start-seen flag.
// - After start, one more period, then start bit clears, data stays low.
// - Line low at start, or clock low before data pulled: collision, idle.
// - Buffer write during start is dropped and sets write collision.
// - Control requests are ignored while a start sequence is incomplete.
// - Repeated start in idle pulls clock low, then releases data a period.
// - Release clock, both high a period, data low a period, clear bit.
// - Start-seen sets on detection; interrupt flag waits for last period.
// - Repeated start request while busy has no effect.
// - Repeated start collides on data low at clock rise or early clock fall.
// - Buffer write during repeated start is dropped, sets write collision.
// - Buffer write sets buffer full, starts counter; clears after 8 bits.
// - Bit set after clock fall; clock low a period, then high a period.
// - After bit 8 release data; ninth clock samples ack into status.
// - After ninth clock set interrupt, hold clock low, counter suspended.
// - Write during transmit sets collision; lands only within 2 instruction cycles.
module i2c_master_bit_sequencer (
	// Clock and reset.
	input wire logic clk_i,
	input wire logic rst_n_i,
	// Configuration.
	input wire logic [i2c_seq_pkg::RELOAD_W-1:0] baud_reload_i,
	// Software requests, one-cycle pulses.
	input wire logic start_req_i,
	input wire logic rstart_req_i,
	input wire logic buf_wr_i,
	input wire logic [i2c_seq_pkg::DATA_W-1:0] buf_data_i,
	input wire logic write_collision_flag_clr_i,
	input wire logic coll_clr_i,
	input wire logic irq_clr_i,
	// Status.
	output logic start_enable_o,
	output logic repeated_start_o,
	output logic buffer_full_o,
	output logic write_collision_o,
	output logic ack_status_o,
	output logic start_seen_o,
	output logic collision_o,
	output logic port_interrupt_o,
	output logic [i2c_seq_pkg::DATA_W-1:0] transfer_buffer_o,
	// Bus lines, open drain.
	input wire logic clock_line_i,
	output logic clock_line_o,
	output logic clock_line_oe_n_o,
	input wire logic data_line_i,
	output logic data_line_o,
	output logic data_line_oe_n_o
);
	import i2c_seq_pkg::*;

	localparam int WIN_W = $clog2(WRITE_COLLISION_FLAG_WIN_CLKS + 1);
	localparam int DIV_W = $clog2(TICK_CLKS + 1);

	// Reset release and pin synchronisers.
	logic rst_meta_r, rst_s_r;
	logic scl_meta_r, scl_s_r, sda_meta_r, sda_s_r, scl_d_r, sda_d_r;
	logic rst_n;

	always_ff @(posedge clk_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rst_meta_r <= 1'b0;
			rst_s_r <= 1'b0;
		end else begin
			rst_meta_r <= 1'b1;
			rst_s_r <= rst_meta_r;
		end
	end
	assign rst_n = rst_s_r;

	// Lines pass two flops before any check reads them.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			scl_meta_r <= 1'b1;
			scl_s_r <= 1'b1;
			sda_meta_r <= 1'b1;
			sda_s_r <= 1'b1;
			scl_d_r <= 1'b1;
			sda_d_r <= 1'b1;
		end else begin
			scl_meta_r <= clock_line_i;
			scl_s_r <= scl_meta_r;
			sda_meta_r <= data_line_i;
			sda_s_r <= sda_meta_r;
			scl_d_r <= scl_s_r;
			sda_d_r <= sda_s_r;
		end
	end

	// Sequencer state.
	seq_state_t state_r, state_nxt;
	logic [RELOAD_W-1:0] brg_r, brg_nxt;
	logic [DIV_W-1:0] div_r, div_nxt;
	logic [WIN_W-1:0] win_r, win_nxt;
	logic [DATA_W-1:0] buf_r, buf_nxt, sh_r, sh_nxt;
	logic [3:0] bitc_r, bitc_nxt;
	logic scl_oen_r, scl_oen_nxt, sda_oen_r, sda_oen_nxt;
	logic sen_r, sen_nxt, repeated_start_bit_r, repeated_start_bit_nxt, bf_r, bf_nxt;
	logic write_collision_flag_r, write_collision_flag_nxt, ack_r, ack_nxt, sseen_r, sseen_nxt;
	logic coll_r, coll_nxt, irq_r, irq_nxt;
	logic tick, expired, timing, start_det, stop_det;

	// Counting happens only in states that time a period; wait states hold
	// the counter, which is what stretches the clock high phase.
	always_comb begin
		timing = (state_r == ST_S_WAIT) || (state_r == ST_S_HOLD) ||
			(state_r == ST_R_SDA) || (state_r == ST_R_BOTH) ||
			(state_r == ST_R_SDAL) || (state_r == ST_TX_LOW) ||
			(state_r == ST_TX_HIGH);
	end
	assign tick = (div_r == DIV_W'(TICK_CLKS - 1));
	assign expired = timing && (brg_r == '0);
	// Bus conditions seen on the sampled lines, whoever made them.
	assign start_det = scl_s_r && scl_d_r && sda_d_r && !sda_s_r;
	assign stop_det = scl_s_r && scl_d_r && !sda_d_r && sda_s_r;

	// Next-state logic of the sequencer, counter and flags.
	always_comb begin
		state_nxt = state_r;
		div_nxt = tick ? '0 : div_r + 1'b1;
		brg_nxt = brg_r;
		win_nxt = win_r;
		buf_nxt = buf_r;
		sh_nxt = sh_r;
		bitc_nxt = bitc_r;
		scl_oen_nxt = scl_oen_r;
		sda_oen_nxt = sda_oen_r;
		sen_nxt = sen_r;
		repeated_start_bit_nxt = repeated_start_bit_r;
		bf_nxt = bf_r;
		write_collision_flag_nxt = write_collision_flag_r;
		ack_nxt = ack_r;
		sseen_nxt = sseen_r;
		coll_nxt = coll_r;
		irq_nxt = irq_r;
		// Down to zero and parked there; each instance has its own.
		if (timing && tick && brg_r != '0) begin
			brg_nxt = brg_r - 1'b1;
		end
		if (win_r != '0) begin
			win_nxt = win_r - 1'b1;
		end
		// Software clears come first so that a hardware set below wins.
		if (write_collision_flag_clr_i) begin
			write_collision_flag_nxt = 1'b0;
		end
		if (coll_clr_i) begin
			coll_nxt = 1'b0;
		end
		if (irq_clr_i) begin
			irq_nxt = 1'b0;
		end
		if (start_det) begin
			sseen_nxt = 1'b1;
		end else if (stop_det) begin
			sseen_nxt = 1'b0;
		end
		unique case (state_r)
			ST_IDLE: begin
				if (start_req_i) begin
					if (scl_s_r && sda_s_r) begin
						sen_nxt = 1'b1;
						brg_nxt = baud_reload_i;
						state_nxt = ST_S_WAIT;
					end else begin
						coll_nxt = 1'b1;
					end
				end else if (rstart_req_i) begin
					// Only idle accepts it.
					repeated_start_bit_nxt = 1'b1;
					scl_oen_nxt = 1'b0;
					state_nxt = ST_R_PULL;
				end else if (buf_wr_i) begin
					buf_nxt = buf_data_i;
					sh_nxt = buf_data_i;
					bf_nxt = 1'b1;
					bitc_nxt = '0;
					win_nxt = WIN_W'(WRITE_COLLISION_FLAG_WIN_CLKS);
					scl_oen_nxt = 1'b0;
					brg_nxt = baud_reload_i;
					state_nxt = ST_TX_LOW;
				end
			end
			ST_S_WAIT: begin
				if (!scl_s_r) begin
					coll_nxt = 1'b1;
					sen_nxt = 1'b0;
					state_nxt = ST_IDLE;
				end else if (expired && sda_s_r) begin
					sda_oen_nxt = 1'b0;
					sseen_nxt = 1'b1;
					brg_nxt = baud_reload_i;
					state_nxt = ST_S_HOLD;
				end else if (expired) begin
					coll_nxt = 1'b1;
					sen_nxt = 1'b0;
					state_nxt = ST_IDLE;
				end
			end
			ST_S_HOLD: begin
				if (expired) begin
					sen_nxt = 1'b0;
					irq_nxt = 1'b1;
					state_nxt = ST_IDLE;
				end
			end
			ST_R_PULL: begin
				if (!scl_s_r) begin
					sda_oen_nxt = 1'b1;
					brg_nxt = baud_reload_i;
					state_nxt = ST_R_SDA;
				end
			end
			ST_R_SDA: begin
				if (expired && sda_s_r) begin
					scl_oen_nxt = 1'b1;
					state_nxt = ST_R_REL;
				end
			end
			ST_R_REL: begin
				if (scl_s_r) begin
					if (!sda_s_r) begin
						coll_nxt = 1'b1;
						repeated_start_bit_nxt = 1'b0;
						state_nxt = ST_IDLE;
					end else begin
						brg_nxt = baud_reload_i;
						state_nxt = ST_R_BOTH;
					end
				end
			end
			ST_R_BOTH: begin
				if (!scl_s_r) begin
					coll_nxt = 1'b1;
					repeated_start_bit_nxt = 1'b0;
					state_nxt = ST_IDLE;
				end else if (expired) begin
					sda_oen_nxt = 1'b0;
					brg_nxt = baud_reload_i;
					state_nxt = ST_R_SDAL;
				end
			end
			ST_R_SDAL: begin
				if (expired) begin
					// Counter is left at zero, not reloaded.
					repeated_start_bit_nxt = 1'b0;
					irq_nxt = 1'b1;
					state_nxt = ST_IDLE;
				end
			end
			ST_TX_LOW: begin
				// Bit goes out while the clock is low; the ninth is
				// released for the acknowledge.
				sda_oen_nxt = (bitc_r == LAST_DATA_BIT) ? 1'b1 : sh_r[DATA_W-1];
				if (expired) begin
					scl_oen_nxt = 1'b1;
					state_nxt = ST_TX_REL;
				end
			end
			ST_TX_REL: begin
				if (scl_s_r) begin
					brg_nxt = baud_reload_i;
					state_nxt = ST_TX_HIGH;
				end
			end
			ST_TX_HIGH: begin
				if (bitc_r != LAST_DATA_BIT && sda_oen_r && !sda_s_r) begin
					// Another master won the data line; back off.
					coll_nxt = 1'b1;
					bf_nxt = 1'b0;
					scl_oen_nxt = 1'b1;
					sda_oen_nxt = 1'b1;
					state_nxt = ST_IDLE;
				end else if (expired) begin
					scl_oen_nxt = 1'b0;
					if (bitc_r == LAST_DATA_BIT) begin
						ack_nxt = sda_s_r;
						irq_nxt = 1'b1;
						state_nxt = ST_IDLE;
					end else begin
						sh_nxt = {sh_r[DATA_W-2:0], 1'b0};
						bitc_nxt = bitc_r + 1'b1;
						if (bitc_r == LAST_DATA_BIT - 1'b1) begin
							bf_nxt = 1'b0;
						end
						brg_nxt = baud_reload_i;
						state_nxt = ST_TX_LOW;
					end
				end
			end
			default: begin
				scl_oen_nxt = 1'b1;
				sda_oen_nxt = 1'b1;
				state_nxt = ST_IDLE;
			end
		endcase
		// Writes outside idle collide; start and repeated start drop the
		// data, transmit keeps a late rewrite only inside the window.
		if (buf_wr_i && state_r != ST_IDLE) begin
			write_collision_flag_nxt = 1'b1;
			if ((state_r == ST_TX_LOW || state_r == ST_TX_REL ||
				state_r == ST_TX_HIGH) && win_r != '0) begin
				buf_nxt = buf_data_i;
				sh_nxt = buf_data_i;
			end
		end
	end

	// Register stage; control requests are simply not sampled unless idle,
	// which keeps them from queueing behind a running sequence.
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			state_r <= ST_IDLE;
			div_r <= '0;
			brg_r <= BAUD_RESET;
			win_r <= '0;
			buf_r <= BUF_RESET;
			sh_r <= BUF_RESET;
			bitc_r <= '0;
			scl_oen_r <= 1'b1;
			sda_oen_r <= 1'b1;
			sen_r <= 1'b0;
			repeated_start_bit_r <= 1'b0;
			bf_r <= 1'b0;
			write_collision_flag_r <= 1'b0;
			ack_r <= 1'b0;
			sseen_r <= 1'b0;
			coll_r <= 1'b0;
			irq_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			div_r <= div_nxt;
			brg_r <= brg_nxt;
			win_r <= win_nxt;
			buf_r <= buf_nxt;
			sh_r <= sh_nxt;
			bitc_r <= bitc_nxt;
			scl_oen_r <= scl_oen_nxt;
			sda_oen_r <= sda_oen_nxt;
			sen_r <= sen_nxt;
			repeated_start_bit_r <= repeated_start_bit_nxt;
			bf_r <= bf_nxt;
			write_collision_flag_r <= write_collision_flag_nxt;
			ack_r <= ack_nxt;
			sseen_r <= sseen_nxt;
			coll_r <= coll_nxt;
			irq_r <= irq_nxt;
		end
	end

	// Line drive value is a constant low; only the enables move.
	logic low_r;
	always_ff @(posedge clk_i or negedge rst_n) begin
		if (!rst_n) begin
			low_r <= 1'b0;
		end else begin
			low_r <= 1'b0;
		end
	end

	// Outputs, all straight from flops.
	assign start_enable_o = sen_r;
	assign repeated_start_o = repeated_start_bit_r;
	assign buffer_full_o = bf_r;
	assign write_collision_o = write_collision_flag_r;
	assign ack_status_o = ack_r;
	assign start_seen_o = sseen_r;
	assign collision_o = coll_r;
	assign port_interrupt_o = irq_r;
	assign transfer_buffer_o = buf_r;
	assign clock_line_o = low_r;
	assign clock_line_oe_n_o = scl_oen_r;
	assign data_line_o = low_r;
	assign data_line_oe_n_o = sda_oen_r;

endmodule : i2c_master_bit_sequencer

// ===== src/i2c_seq_pkg.sv
// Constants shared by the master bit sequencer: bit positions, reset values,
// timing figures and the sequencer state encoding.
// Assumes a single system clock and software-side control pulses on the same
// clock.
package i2c_seq_pkg;

	// Clock period of the system clock and instruction-cycle length.
	localparam int CLK_PERIOD_NS = 8;
	localparam int INSTR_CYCLE_NS = 32;
	localparam int TCY_CLKS = (INSTR_CYCLE_NS + CLK_PERIOD_NS - 1) /
		CLK_PERIOD_NS;

	// The baud counter steps twice per instruction cycle.
	localparam int TICKS_PER_TCY = 2;
	localparam int TICK_CLKS = (TCY_CLKS / TICKS_PER_TCY < 1) ? 1 :
		TCY_CLKS / TICKS_PER_TCY;

	// Window in which a buffer rewrite still lands, in instruction cycles.
	localparam int WRITE_COLLISION_FLAG_WIN_TCY = 2;
	localparam int WRITE_COLLISION_FLAG_WIN_CLKS = WRITE_COLLISION_FLAG_WIN_TCY * TCY_CLKS;

	// Field widths and positions of the control and status words.
	localparam int RELOAD_W = 7;
	localparam int DATA_W = 8;
	localparam int CTRL2_START_BIT = 0;
	localparam int CTRL2_RSTART_BIT = 1;
	localparam int CTRL2_ACK_BIT = 6;
	localparam int STAT_FULL_BIT = 0;
	localparam int STAT_START_BIT = 3;
	localparam logic [3:0] LAST_DATA_BIT = 4'h8;

	// Reset values.
	localparam logic [DATA_W-1:0] BUF_RESET = 8'h00;
	localparam logic [RELOAD_W-1:0] BAUD_RESET = 7'h00;

	// Sequencer states, Gray coded along the repeated start path.
	typedef enum logic [3:0] {
		ST_IDLE = 4'h0,
		ST_S_WAIT = 4'h1,
		ST_S_HOLD = 4'h3,
		ST_R_PULL = 4'h2,
		ST_R_SDA = 4'h6,
		ST_R_REL = 4'h7,
		ST_R_BOTH = 4'h5,
		ST_R_SDAL = 4'h4,
		ST_TX_LOW = 4'hc,
		ST_TX_REL = 4'hd,
		ST_TX_HIGH = 4'hf
	} seq_state_t;

endpackage : i2c_seq_pkg
